/* File: fault_host.sv */
`timescale 1ns/1ps
module fault_host (
    input logic core_clk,
    input logic [7:0] reg_rdata,
    output fault_regs_pkg::reg_req_t reg_req
);
    initial reg_req = '0;
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        reg_req = '{addr: a, wr: 1'b1, wdata: d};
        @(posedge core_clk) #1;
        reg_req.wr = 1'b0;
        // Stale data must not look valid
        reg_req.wdata = ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) #1;
        reg_req.addr = a;
        @(posedge core_clk) #1;
        d = reg_rdata;
    endtask
endmodule // fault_host

/* File: fault_regs_chk.sv */
`timescale 1ns/1ps
module fault_regs_chk (
    input logic core_clk,
    input logic reset,
    input fault_regs_pkg::reg_req_t reg_req,
    input logic [7:0] reg_rdata,
    input fault_regs_pkg::fault_inputs_t fault_in,
    input logic fault_latch_select,
    input logic [2:0] avg_current_limit_code,
    input logic [6:0] limit_threshold_mv,
    input logic alert
);
    logic [4:0] mask_q;
    always_ff @(posedge core_clk) begin
        if (reset)
            mask_q <= 5'h01;
        else if (reg_req.wr && reg_req.addr == 8'h06)
            mask_q <= reg_req.wdata[4:0];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_CODE: assert property (reg_req.wr && reg_req.addr == 8'h04
        |=> avg_current_limit_code == $past(reg_req.wdata[2:0]))
        else $error("code");
    AST_THR: assert property (avg_current_limit_code == 3'h3
        |-> limit_threshold_mv == 7'h2D) else $error("thr");
    AST_OT: assert property ($rose(fault_in.overtemp) && mask_q == 5'h00
        |-> ##[1:4] alert) else $error("ot");
    AST_HOLD: assert property (alert && fault_latch_select && !reg_req.wr
        |=> alert) else $error("hold");
    AST_CLR: assert property (reg_req.wr && reg_req.addr == 8'h05
        && reg_req.wdata == 8'hFF && $past(fault_in) == 9'h000
        && $past(fault_in, 2) == 9'h000 |=> !alert) else $error("clr");
    AST_MASK: assert property (mask_q == 5'h1F |-> !alert)
        else $error("mask");
    AST_RDM: assert property (reg_req.addr == 8'h06
        |=> reg_rdata == {3'h0, $past(mask_q)}) else $error("rdm");
    AST_LIVE: assert property ((!fault_latch_select
        && fault_in == 9'h000) [*5] ##1 reg_req.addr == 8'h05
        |=> reg_rdata[1:0] == 2'h0) else $error("live");
    COV_CLR: cover property (reg_req.wr && reg_req.wdata == 8'hFF && alert);
    COV_OT: cover property ($rose(alert));
    COV_LATCH: cover property (fault_latch_select && alert);
endmodule // fault_regs_chk

/* File: fault_regs_pkg.sv */
package fault_regs_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] CURRENT_LIMIT_SELECT_OFS = 8'h04;
    localparam logic [7:0] FAULT_STATUS_OFS = 8'h05;
    localparam logic [7:0] FAULT_ALERT_MASK_OFS = 8'h06;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int OVERTEMP_BIT = 4;
    localparam int AVG_LIMIT_BIT = 3;
    localparam int OVERVOLTAGE_BIT = 2;
    localparam int SWITCH_LIMIT_BIT = 1;
    localparam int POWER_NOT_GOOD_BIT = 0;
    localparam int FLAG_COUNT = 5;

    localparam logic [2:0] AVG_CURRENT_LIMIT_CODE_RST = 3'h7;
    localparam logic [4:0] FAULT_FLAGS_RST = 5'h00;
    localparam logic [4:0] FAULT_ALERT_MASK_RST = 5'h01;
    localparam logic [7:0] FAULT_CLEAR_VALUE = 8'hFF;

    // Flags that always latch; the others follow fault_latch_select
    localparam logic [4:0] ALWAYS_LATCHED = 5'h1C;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Raw analog comparator levels, asynchronous to core_clk
    typedef struct packed {
        logic overtemp;
        logic current_above_avg;
        logic output_dropping;
        logic overvoltage;
        logic cycle_limit_hit;
        logic feedback_below_60pct;
        logic soft_start_done;
        logic vout_above_upper;
        logic vout_below_lower;
    } fault_inputs_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } reg_req_t;

    // Sense threshold in millivolts for each limit code
    function automatic logic [6:0] limit_threshold_mv(
        input logic [2:0] code
    );
        case (code)
            3'h0: limit_threshold_mv = 7'd26;
            3'h1: limit_threshold_mv = 7'd32;
            3'h2: limit_threshold_mv = 7'd38;
            3'h3: limit_threshold_mv = 7'd45;
            3'h4: limit_threshold_mv = 7'd50;
            3'h5: limit_threshold_mv = 7'd56;
            3'h6: limit_threshold_mv = 7'd62;
            default: limit_threshold_mv = 7'd68;
        endcase
    endfunction

endpackage

/* File: fault_status_and_current_limit_regs.sv */
`timescale 1ns/1ps
module fault_status_and_current_limit_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire fault_regs_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire fault_regs_pkg::fault_inputs_t fault_in,
    input wire logic fault_latch_select,
    output logic [2:0] avg_current_limit_code,
    output logic [6:0] limit_threshold_mv,
    output logic alert
);
    import fault_regs_pkg::*;

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (ADDR_W != 8) begin : g_bad_addr_w
        $error("ADDR_W must be 8 to match the register offsets");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        fault_inputs_t sync1;
        fault_inputs_t sync2;
        logic [2:0] limit_code;
        logic [4:0] flags;
        logic [4:0] mask;
        logic [7:0] rdata;
        logic [6:0] threshold;
        logic alert;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [4:0] live;
    logic clear_flags;
    logic [4:0] latch_en;

    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers; only sync2 is read by logic
        s_d.sync1 = fault_in;
        s_d.sync2 = s_q.sync1;

        live = '0;
        live[OVERTEMP_BIT] = s_q.sync2.overtemp;
        live[AVG_LIMIT_BIT] = s_q.sync2.current_above_avg
            & s_q.sync2.output_dropping;
        live[OVERVOLTAGE_BIT] = s_q.sync2.overvoltage;
        live[SWITCH_LIMIT_BIT] = s_q.sync2.cycle_limit_hit
            & s_q.sync2.feedback_below_60pct
            & s_q.sync2.soft_start_done;
        live[POWER_NOT_GOOD_BIT] = s_q.sync2.vout_above_upper
            | s_q.sync2.vout_below_lower;

        clear_flags = reg_req.wr && reg_req.addr == FAULT_STATUS_OFS
            && reg_req.wdata == FAULT_CLEAR_VALUE;

        latch_en = ALWAYS_LATCHED;
        if (fault_latch_select) begin
            latch_en = '1;
        end

        // A condition present in the clear cycle survives the clear
        for (int i = 0; i < FLAG_COUNT; i++) begin
            if (latch_en[i]) begin
                s_d.flags[i] = (s_q.flags[i] & ~clear_flags) | live[i];
            end else begin
                s_d.flags[i] = live[i];
            end
        end

        if (reg_req.wr && reg_req.addr == CURRENT_LIMIT_SELECT_OFS) begin
            s_d.limit_code = reg_req.wdata[2:0];
        end
        if (reg_req.wr && reg_req.addr == FAULT_ALERT_MASK_OFS) begin
            s_d.mask = reg_req.wdata[4:0];
        end

        // The output port shares this name, so the package is named
        s_d.threshold = fault_regs_pkg::limit_threshold_mv(
            s_d.limit_code);

        // Masks gate only the alert; flags stay visible
        s_d.alert = |(s_d.flags & ~s_d.mask);

        case (reg_req.addr)
            CURRENT_LIMIT_SELECT_OFS: begin
                s_d.rdata = {5'h00, s_q.limit_code};
            end
            FAULT_STATUS_OFS: begin
                s_d.rdata = {3'h0, s_q.flags};
            end
            FAULT_ALERT_MASK_OFS: begin
                s_d.rdata = {3'h0, s_q.mask};
            end
            default: begin
                s_d.rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.limit_code <= AVG_CURRENT_LIMIT_CODE_RST;
            s_q.flags <= FAULT_FLAGS_RST;
            s_q.mask <= FAULT_ALERT_MASK_RST;
            s_q.threshold <= 7'd68;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign avg_current_limit_code = s_q.limit_code;
    assign limit_threshold_mv = s_q.threshold;
    assign alert = s_q.alert;

endmodule // fault_status_and_current_limit_regs

/* File: fault_status_and_current_limit_regs_tb_top.sv */
`timescale 1ns/1ps
module fault_status_and_current_limit_regs_tb_top;
    import fault_regs_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic fault_latch_select = 1'b0;
    fault_inputs_t fault_in = '0;
    reg_req_t reg_req;
    logic [7:0] reg_rdata, rd;
    logic [2:0] avg_current_limit_code;
    logic [6:0] limit_threshold_mv;
    logic alert;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    logic [6:0] rows [8] = '{7'h1A, 7'h20, 7'h26, 7'h2D, 7'h32, 7'h38,
        7'h3E, 7'h44};
    fault_status_and_current_limit_regs i_dut (.*);
    fault_host i_host (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_req(reg_req));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic st(input logic [8:0] f, input logic [7:0] exp);
        fault_in = f;
        repeat (5) @(posedge core_clk);
        i_host.get(8'h05, rd);
        chk(rd, exp);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1 reset = 1'b0;
        i_host.get(8'h04, rd);
        chk(rd, 8'h07);
        i_host.get(8'h06, rd);
        chk(rd, 8'h01);
        for (int i = 0; i < 8; i++) begin
            i_host.put(8'h04, 8'hF8 | i[7:0]);
            chk({1'b0, limit_threshold_mv}, {1'b0, rows[i]});
            i_host.get(8'h04, rd);
            chk(rd, i[7:0]);
        end
        i_host.put(8'h06, 8'h00);
        st(9'h100, 8'h10);
        chk({7'h0, alert}, 8'h01);
        st(9'h000, 8'h10);
        i_host.put(8'h06, 8'h10);
        chk({7'h0, alert}, 8'h00);
        i_host.put(8'h05, 8'hFF);
        st(9'h0C0, 8'h08);
        st(9'h020, 8'h0C);
        i_host.put(8'h06, 8'h1F);
        chk({7'h0, alert}, 8'h00);
        st(9'h01C, 8'h0E);
        st(9'h018, 8'h0C);
        st(9'h002, 8'h0D);
        st(9'h000, 8'h0C);
        fault_latch_select = 1'b1;
        st(9'h01C, 8'h0E);
        st(9'h000, 8'h0E);
        i_host.put(8'h06, 8'h00);
        chk({7'h0, alert}, 8'h01);
        i_host.put(8'h05, 8'hFF);
        st(9'h000, 8'h00);
        chk({7'h0, alert}, 8'h00);
        st(9'h001, 8'h01);
        chk({7'h0, alert}, 8'h01);
        i_host.put(8'h06, 8'h01);
        chk({7'h0, alert}, 8'h00);
        st(9'h000, 8'h01);
        i_host.put(8'h05, 8'hFF);
        st(9'h01C, 8'h02);
        i_host.put(8'h06, 8'h02);
        chk({7'h0, alert}, 8'h00);
        i_host.put(8'h06, 8'h00);
        chk({7'h0, alert}, 8'h01);
        fault_in = '0;
        reset = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        chk({7'h0, alert}, 8'h00);
        i_host.get(8'h06, rd);
        chk(rd, 8'h01);
        i_host.get(8'h05, rd);
        chk(rd, 8'h00);
        i_host.get(8'h04, rd);
        chk(rd, 8'h07);
        st(9'h020, 8'h04);
        chk({7'h0, alert}, 8'h01);
        i_host.put(8'h06, 8'h04);
        chk({7'h0, alert}, 8'h00);
        finish_test();
    end
endmodule // fault_status_and_current_limit_regs_tb_top
bind fault_status_and_current_limit_regs fault_regs_chk i_chk (.*);
